// ---- ext_ctrl_pkg.sv ----
// Purpose: shared constants, field layout and symbol tables for the extended control block
// Assumes: 16-bit management registers, 5-bit management register address
// Notes:   bit positions and defaults are used by the bank, the encoder and the checks
package ext_ctrl_pkg;
   // register location and width
   localparam int          REG_W         = 16;
   localparam int          MADDR_W       = 5;
   localparam logic [4:0]  EXT_CTRL_ADDR = 5'h10;

   // field positions
   localparam int          OVR_BIT       = 15;
   localparam int          ADDR_HI       = 10;
   localparam int          ADDR_LO       = 6;
   localparam int          SCR_TEST_BIT  = 5;
   localparam int          NRZI_BIT      = 3;
   localparam int          INV_TEST_BIT  = 2;
   localparam int          SCR_DIS_BIT   = 0;
   localparam logic [15:0] RSVD_MASK     = 16'h7812;

   // reset values of the writable fields
   localparam logic        OVR_RST       = 1'b0;
   localparam logic        SCR_TEST_RST  = 1'b0;
   localparam logic        NRZI_RST      = 1'b1;
   localparam logic        INV_TEST_RST  = 1'b0;
   localparam logic        SCR_DIS_RST   = 1'b0;

   // data path shape
   localparam int          NIB_W         = 4;
   localparam int          SYM_W         = 5;
   localparam int          FIFO_W        = NIB_W + 1;
   localparam int          FIFO_DEPTH    = 16;
   localparam int          PA_W          = 5;
   localparam logic [2:0]  SYM_BITS      = 3'h5;
   localparam logic [1:0]  STRAP_WAIT    = 2'h3;
   localparam logic [4:0]  HALT_SYM      = 5'h04;

   // standard 4b/5b data code groups
   function automatic logic [4:0] enc_std(input logic [3:0] nib);
      logic [4:0] s;
      s = 5'h1e;
      case (nib)
         4'h0: s = 5'h1e;
         4'h1: s = 5'h09;
         4'h2: s = 5'h14;
         4'h3: s = 5'h15;
         4'h4: s = 5'h0a;
         4'h5: s = 5'h0b;
         4'h6: s = 5'h0e;
         4'h7: s = 5'h0f;
         4'h8: s = 5'h12;
         4'h9: s = 5'h13;
         4'ha: s = 5'h16;
         4'hb: s = 5'h17;
         4'hc: s = 5'h1a;
         4'hd: s = 5'h1b;
         4'he: s = 5'h1c;
         default: s = 5'h1d;
      endcase
      return s;
   endfunction : enc_std

   // test translation used with tx error in invalid-code mode
   function automatic logic [4:0] enc_invalid(input logic [3:0] nib);
      logic [4:0] s;
      s = {1'b0, nib};
      case (nib)
         4'h8: s = 5'h00;
         4'h9: s = 5'h0d;
         4'ha: s = 5'h0c;
         4'hb: s = 5'h11;
         4'hc: s = 5'h10;
         4'hd: s = 5'h19;
         4'he: s = 5'h18;
         4'hf: s = 5'h1f;
         default: s = {1'b0, nib};
      endcase
      return s;
   endfunction : enc_invalid
endpackage : ext_ctrl_pkg

// ---- nibble_stream_if.sv ----
// Purpose: valid/ready word stream between the block's own modules
// Assumes: single clock, transfer when valid and ready are both high
// Notes:   data carries {tx error, nibble}
`timescale 1ns/1ps
interface nibble_stream_if #(parameter int W = 5) ();
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : nibble_stream_if

// ---- tx_nibble_fifo.sv ----
// Purpose: small synchronous fifo holding transmit nibbles ahead of the encoder
// Assumes: DEPTH is a power of two
// Notes:   read data and ready both come from registers
`timescale 1ns/1ps
module tx_nibble_fifo #(
   parameter int W     = 5,
   parameter int DEPTH = 16
) (
   input  wire logic       clk_sys_i,
   input  wire logic       sys_rst_i,
   nibble_stream_if.snk    in_s,
   nibble_stream_if.src    out_s
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0]   FULL_CNT = (PW+1)'(DEPTH);
   localparam logic [PW-1:0] PTR_ONE  = PW'(1);
   localparam logic [PW:0]   CNT_ONE  = (PW+1)'(1);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0]           wp;
      logic [PW-1:0]           rp;
      logic [PW:0]             cnt;
      logic                    full;
      logic                    ov;
      logic [W-1:0]            od;
   } fifo_s;

   fifo_s s;
   fifo_s next_s;
   logic  push;
   logic  pop;

   // storage, pointers and registered output stage
   always_comb
   begin
      next_s = s;
      push   = in_s.valid && !s.full;
      pop    = (s.cnt != '0) && (!s.ov || out_s.ready);
      if (out_s.ready && s.ov)
      begin
         next_s.ov = 1'b0;
      end
      if (pop)
      begin
         next_s.od = s.mem[s.rp];
         next_s.ov = 1'b1;
         next_s.rp = s.rp + PTR_ONE;
      end
      if (push)
      begin
         next_s.mem[s.wp] = in_s.data;
         next_s.wp        = s.wp + PTR_ONE;
      end
      if (push && !pop)
      begin
         next_s.cnt = s.cnt + CNT_ONE;
      end
      else if (pop && !push)
      begin
         next_s.cnt = s.cnt - CNT_ONE;
      end
      // full is registered so the upstream ready never sees a comb path
      next_s.full = (next_s.cnt == FULL_CNT);
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign in_s.ready  = !s.full;
   assign out_s.valid = s.ov;
   assign out_s.data  = s.od;
endmodule : tx_nibble_fifo

// ---- phy_extended_control.sv ----
// Purpose: extended control register bank with strap capture and transmit test encoder
// Assumes: management accesses arrive decoded as one-cycle strobes on clk_sys_i
// Notes:   scrambler itself lives elsewhere; this block drives its controls
`timescale 1ns/1ps
module phy_extended_control (
   input  wire logic                           clk_sys_i,
   input  wire logic                           sys_rst_i,
   input  wire logic                           soft_rst_i,
   input  wire logic                           speed_100_i,
   input  wire logic                           addr4_strap_pin_i,
   input  wire logic                           addr3_strap_pin_i,
   input  wire logic                           addr2_strap_pin_i,
   input  wire logic                           addr1_strap_pin_i,
   input  wire logic                           addr0_strap_pin_i,
   input  wire logic [ext_ctrl_pkg::MADDR_W-1:0] mgmt_addr_i,
   input  wire logic                           mgmt_wr_i,
   input  wire logic                           mgmt_rd_i,
   input  wire logic [ext_ctrl_pkg::REG_W-1:0] mgmt_wdata_i,
   output logic      [ext_ctrl_pkg::REG_W-1:0] mgmt_rdata_o,
   output logic                                mgmt_rvalid_o,
   output logic                                override_en_o,
   output logic                                prot_wr_o,
   output logic      [ext_ctrl_pkg::PA_W-1:0]  phy_addr_o,
   input  wire logic                           tx_valid_i,
   output logic                                tx_ready_o,
   input  wire logic [ext_ctrl_pkg::NIB_W-1:0] tx_nibble_i,
   input  wire logic                           tx_er_i,
   output logic                                tx_bit_o,
   output logic                                scr_bypass_o,
   output logic                                descr_unlock_o
);
   import ext_ctrl_pkg::*;

   typedef struct packed {
      logic [PA_W-1:0]  sync1;
      logic [PA_W-1:0]  sync2;
      logic [1:0]       cap_cnt;
      logic             captured;
      logic [PA_W-1:0]  paddr;
      logic             ovr;
      logic             scr_test;
      logic             nrzi;
      logic             inv_test;
      logic             scr_dis;
      logic [REG_W-1:0] rdata;
      logic             rvalid;
      logic             prot_wr;
      logic [SYM_W-1:0] shreg;
      logic [2:0]       left;
      logic             level;
      logic             scr_byp;
      logic             unlock;
   } ctrl_s;

   // whole state in one record so a single register process owns it
   ctrl_s               s;
   ctrl_s               next_s;
   // helpers decoded every cycle from the state and the management address
   logic                hit;
   logic                bit_now;
   logic                emitting;
   logic                load;
   logic [NIB_W-1:0]    fifo_nib;
   logic                fifo_er;
   logic [REG_W-1:0]    reg_view;

   nibble_stream_if #(.W(FIFO_W)) wr_if ();
   nibble_stream_if #(.W(FIFO_W)) rd_if ();

   // the buffer absorbs bursts while symbols leave at one bit per clock
   // nibble buffer ahead of the encoder
   assign wr_if.valid = tx_valid_i;
   assign wr_if.data  = {tx_er_i, tx_nibble_i};
   assign tx_ready_o  = wr_if.ready;

   tx_nibble_fifo #(
      .W     (FIFO_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .in_s      (wr_if),
      .out_s     (rd_if)
   );

   assign fifo_nib    = rd_if.data[NIB_W-1:0];
   assign fifo_er     = rd_if.data[NIB_W];
   assign emitting    = (s.left != '0);
   assign bit_now     = s.shreg[SYM_W-1];
   // the encoder takes a new symbol while the last bit of the old one leaves
   assign rd_if.ready = (s.left <= 3'h1);
   assign load        = rd_if.ready && rd_if.valid;

   // read view of the register
   always_comb
   begin
      reg_view                  = '0;
      reg_view                  = reg_view & ~RSVD_MASK;
      reg_view[OVR_BIT]         = s.ovr;
      reg_view[ADDR_HI:ADDR_LO] = s.paddr;
      reg_view[SCR_TEST_BIT]    = s.scr_test;
      reg_view[NRZI_BIT]        = s.nrzi;
      reg_view[INV_TEST_BIT]    = s.inv_test;
      reg_view[SCR_DIS_BIT]     = s.scr_dis;
   end

   // next state of bank, strap capture and serializer
   always_comb
   begin
      next_s         = s;
      hit            = (mgmt_addr_i == EXT_CTRL_ADDR);
      // strap pins are asynchronous: two flops before the capture reads them
      next_s.sync1   = {addr4_strap_pin_i, addr3_strap_pin_i, addr2_strap_pin_i,
                        addr1_strap_pin_i, addr0_strap_pin_i};
      next_s.sync2   = s.sync1;
      if (!s.captured)
      begin
         next_s.cap_cnt = s.cap_cnt + 2'h1;
         if (s.cap_cnt == STRAP_WAIT)
         begin
            next_s.paddr    = s.sync2;
            next_s.captured = 1'b1;
         end
      end
      // register read answers one cycle later; other addresses are not ours
      next_s.rvalid  = mgmt_rd_i && hit;
      next_s.rdata   = (mgmt_rd_i && hit) ? reg_view : s.rdata;
      // the strobe lets other registers accept their protected bits
      // strobe only when unlocked
      next_s.prot_wr = mgmt_wr_i && s.ovr;
      if (mgmt_wr_i)
      begin
         next_s.ovr = hit ? mgmt_wdata_i[OVR_BIT] : 1'b0;
         if (hit)
         begin
            next_s.scr_test = mgmt_wdata_i[SCR_TEST_BIT];
            next_s.nrzi     = mgmt_wdata_i[NRZI_BIT];
            next_s.inv_test = mgmt_wdata_i[INV_TEST_BIT];
            next_s.scr_dis  = mgmt_wdata_i[SCR_DIS_BIT];
         end
      end
      // soft reset comes last so it beats a same-cycle write
      // soft reset keeps address
      if (soft_rst_i)
      begin
         next_s.ovr      = OVR_RST;
         next_s.scr_test = SCR_TEST_RST;
         next_s.nrzi     = NRZI_RST;
         next_s.inv_test = INV_TEST_RST;
         next_s.scr_dis  = SCR_DIS_RST;
      end
      next_s.scr_byp = s.scr_dis && speed_100_i;
      next_s.unlock  = s.scr_test && speed_100_i;
      // at 10 Mb/s raw bits go out; the line coder is a 100 Mb/s feature
      // line coding of each bit
      if (emitting)
      begin
         next_s.shreg = s.shreg << 1;
         next_s.left  = s.left - 3'h1;
         next_s.level = (speed_100_i && s.nrzi) ? (s.level ^ bit_now) : bit_now;
      end
      if (load)
      begin
         next_s.left = SYM_BITS;
         if (s.inv_test && fifo_er)
         begin
            next_s.shreg = enc_invalid(fifo_nib);
         end
         else if (fifo_er)
         begin
            next_s.shreg = HALT_SYM; // error without test mode marks a halt
         end
         else
         begin
            next_s.shreg = enc_std(fifo_nib);
         end
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         s          <= '0;
         // nrzi is the only writable field whose default is one
         s.nrzi     <= NRZI_RST;
      end
      else
      begin
         s <= next_s;
      end
   end

   // outputs straight from the state register
   assign mgmt_rdata_o   = s.rdata;
   assign mgmt_rvalid_o  = s.rvalid;
   assign override_en_o  = s.ovr;
   assign prot_wr_o      = s.prot_wr;
   assign phy_addr_o     = s.paddr;
   assign tx_bit_o       = s.level;
   assign scr_bypass_o   = s.scr_byp;
   assign descr_unlock_o = s.unlock;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);
   // reset cancels any check in flight; all sampled on the system clock

   ovr_clear_a: assert property (mgmt_wr_i && !hit |=> !override_en_o)
      else $error("override enable survived a write");
   rsvd_zero_a: assert property (mgmt_rvalid_o |-> (mgmt_rdata_o & RSVD_MASK) == '0)
      else $error("reserved bits read nonzero");
   strap_take_a: assert property (!s.captured && s.cap_cnt == STRAP_WAIT
                                  |=> phy_addr_o == $past(s.sync2) && s.captured)
      else $error("strap address not captured");
   addr_hold_a: assert property (s.captured |=> $stable(phy_addr_o))
      else $error("port address changed after capture");
   unlock_set_a: assert property (s.scr_test && speed_100_i |=> descr_unlock_o)
      else $error("descrambler unlock not forced");
   nrzi_bit_a: assert property (emitting && speed_100_i && s.nrzi
                                |=> tx_bit_o == ($past(tx_bit_o) ^ $past(bit_now)))
      else $error("nrzi line bit wrong");
   nrz_bit_a: assert property (emitting && !s.nrzi |=> tx_bit_o == $past(bit_now))
      else $error("nrz line bit wrong");
   std_code_a: assert property (load && !fifo_er
                                |=> s.shreg == enc_std($past(fifo_nib)))
      else $error("standard code group wrong");
   inv_low_a: assert property (load && s.inv_test && fifo_er && !fifo_nib[NIB_W-1]
                               |=> s.shreg == {1'b0, $past(fifo_nib)})
      else $error("low test symbol wrong");
   inv_idle_a: assert property (load && s.inv_test && fifo_er && fifo_nib == 4'hf
                                |=> s.shreg == 5'h1f)
      else $error("high test symbol wrong");
   bypass_on_a: assert property (s.scr_dis && speed_100_i |=> scr_bypass_o)
      else $error("scrambler bypass missing");
   slow_off_a: assert property (!speed_100_i |=> !scr_bypass_o && !descr_unlock_o)
      else $error("scrambler control active at 10 Mb/s");
   prot_lock_a: assert property (mgmt_wr_i && !override_en_o |=> !prot_wr_o)
      else $error("protected write without override");

   // further checks on the bank and the encoder
   ovr_set_a: assert property (mgmt_wr_i && hit && !soft_rst_i
                               |=> override_en_o == $past(mgmt_wdata_i[OVR_BIT]))
      else $error("override enable not loaded from the write");
   prot_pulse_a: assert property (mgmt_wr_i && override_en_o
                                  |=> prot_wr_o)
      else $error("unlocked write gave no protected strobe");
   rd_addr_a: assert property (mgmt_rd_i && hit |=> mgmt_rvalid_o
                               && mgmt_rdata_o[ADDR_HI:ADDR_LO] == $past(phy_addr_o))
      else $error("read answer lacks the port address");
   inv_nine_a: assert property (load && s.inv_test && fifo_er && fifo_nib == 4'h9
                                |=> s.shreg == 5'h0d)
      else $error("test symbol for nibble nine wrong");
   halt_code_a: assert property (load && !s.inv_test && fifo_er
                                 |=> s.shreg == HALT_SYM)
      else $error("error nibble not sent as halt");
   line_hold_a: assert property (!emitting
                                 |=> tx_bit_o == $past(tx_bit_o))
      else $error("line bit moved while idle");
   test_off_a: assert property (!s.scr_test
                                |=> !descr_unlock_o)
      else $error("descrambler unlock without test mode");
   bypass_off_a: assert property (!s.scr_dis
                                  |=> !scr_bypass_o)
      else $error("scrambler bypass without disable bit");
   slow_raw_a: assert property (emitting && !speed_100_i
                                |=> tx_bit_o == $past(bit_now))
      else $error("line coder active at 10 Mb/s");

   // scenarios the bench should reach
   override_use_c: cover property (override_en_o && mgmt_wr_i ##1 prot_wr_o);
   slow_line_c:    cover property (emitting && !speed_100_i);
   invalid_sent_c: cover property (load && s.inv_test && fifo_er);
   fifo_full_c:    cover property (tx_valid_i && !tx_ready_o);
   soft_reset_c:   cover property (s.captured && soft_rst_i);
endmodule : phy_extended_control

// ---- mgmt_model.sv ----
// Purpose: station management controller model driving decoded register strobes
// Assumes: strobes change on the falling clock edge and last one cycle
// Notes:   reserved bits go out at their default of zero only during a write strobe
`timescale 1ns/1ps
module mgmt_model
   import ext_ctrl_pkg::*;
(
   input  wire logic                               clk_sys_i,
   input  wire logic [ext_ctrl_pkg::REG_W-1:0]     mgmt_rdata_i,
   input  wire logic                               mgmt_rvalid_i,
   output logic      [ext_ctrl_pkg::MADDR_W-1:0]   mgmt_addr_o,
   output logic                                    mgmt_wr_o,
   output logic                                    mgmt_rd_o,
   output logic      [ext_ctrl_pkg::REG_W-1:0]     mgmt_wdata_o
);
   // idle bus at time zero
   initial
   begin
      mgmt_addr_o  = 5'h1f;
      mgmt_wr_o    = 1'b0;
      mgmt_rd_o    = 1'b0;
      mgmt_wdata_o = 16'h5a5a;
   end

   // one write strobe; released bus shows inverted values, not stale ones
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(negedge clk_sys_i);
      mgmt_addr_o  = a;
      mgmt_wdata_o = d & ~RSVD_MASK;
      mgmt_wr_o    = 1'b1;
      @(negedge clk_sys_i);
      mgmt_wr_o    = 1'b0;
      mgmt_wdata_o = ~mgmt_wdata_o;
      mgmt_addr_o  = ~mgmt_addr_o;
   endtask : wr

   // arm override, then the protected write
   task automatic wr_prot(input logic [4:0] a, input logic [15:0] d);
      wr(EXT_CTRL_ADDR, 16'h8008);
      wr(a, d);
   endtask : wr_prot

   // one read strobe, answer looked for over a few cycles
   task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
      int k;
      ok = 1'b0;
      d  = 16'h0;
      @(negedge clk_sys_i);
      mgmt_addr_o = a;
      mgmt_rd_o   = 1'b1;
      for (k = 0; k < 4; k++)
      begin
         @(negedge clk_sys_i);
         mgmt_rd_o = 1'b0;
         if (mgmt_rvalid_i === 1'b1)
         begin
            ok = 1'b1;
            d  = mgmt_rdata_i;
         end
      end
   endtask : rd
endmodule : mgmt_model

// ---- phy_extended_control_tb_top.sv ----
// Purpose: self-checking bench for the extended control register and transmit encoder
// Assumes: inputs change on the falling edge, outputs sampled there too
// Notes:   random values come from a fixed seed so runs repeat
`timescale 1ns/1ps
module phy_extended_control_tb_top;
   import ext_ctrl_pkg::*;
   // standard code groups, nibble f down to 0, and upper half of the test table
   localparam logic [79:0] STD_T  = {5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h17, 5'h16, 5'h13, 5'h12,
                                     5'h0f, 5'h0e, 5'h0b, 5'h0a, 5'h15, 5'h14, 5'h09, 5'h1e};
   localparam logic [39:0] TST_HI = {5'h1f, 5'h18, 5'h19, 5'h10, 5'h11, 5'h0c, 5'h0d, 5'h00};
   logic        clk_sys_i, sys_rst_i, soft_rst_i, speed_100_i, tx_valid_i, tx_er_i;
   logic [3:0]  tx_nibble_i;
   logic [4:0]  strap, cap, mgmt_addr;
   logic        mgmt_wr, mgmt_rd, mgmt_rvalid, override_en_o, prot_wr_o, tx_ready_o;
   logic        tx_bit_o, scr_bypass_o, descr_unlock_o, ok, inv, nrzi;
   logic [15:0] mgmt_wdata, mgmt_rdata, d, w;
   logic [4:0]  phy_addr_o;
   int          failures, n_checks, k, m;

   phy_extended_control i_phy_extended_control (
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst_i),
      .speed_100_i(speed_100_i), .addr4_strap_pin_i(strap[4]), .addr3_strap_pin_i(strap[3]),
      .addr2_strap_pin_i(strap[2]), .addr1_strap_pin_i(strap[1]),
      .addr0_strap_pin_i(strap[0]), .mgmt_addr_i(mgmt_addr), .mgmt_wr_i(mgmt_wr),
      .mgmt_rd_i(mgmt_rd), .mgmt_wdata_i(mgmt_wdata), .mgmt_rdata_o(mgmt_rdata),
      .mgmt_rvalid_o(mgmt_rvalid), .override_en_o(override_en_o), .prot_wr_o(prot_wr_o),
      .phy_addr_o(phy_addr_o), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
      .tx_nibble_i(tx_nibble_i), .tx_er_i(tx_er_i), .tx_bit_o(tx_bit_o),
      .scr_bypass_o(scr_bypass_o), .descr_unlock_o(descr_unlock_o));

   mgmt_model i_mgmt_model (
      .clk_sys_i(clk_sys_i), .mgmt_rdata_i(mgmt_rdata), .mgmt_rvalid_i(mgmt_rvalid),
      .mgmt_addr_o(mgmt_addr), .mgmt_wr_o(mgmt_wr), .mgmt_rd_o(mgmt_rd),
      .mgmt_wdata_o(mgmt_wdata));

   // 50 MHz system clock
   always #10 clk_sys_i = ~clk_sys_i;

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("FAIL t=%0t value %h expected %h", $time, got, exp);
      end
   endtask : chk16

   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("FAIL t=%0t bit %b expected %b", $time, got, exp);
      end
   endtask : chk_bit

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude

   // expected symbol for a nibble under the current test setting
   function automatic logic [4:0] exp_sym(input logic [3:0] n, input logic er);
      int i;
      i = n;
      if (inv && er)
         return n[3] ? TST_HI[(i - 8) * 5 +: 5] : {1'b0, n};
      if (er)
         return HALT_SYM;
      return STD_T[i * 5 +: 5];
   endfunction : exp_sym

   // hardware reset held five cycles, then time for the strap capture
   task automatic hw_reset;
      @(negedge clk_sys_i);
      sys_rst_i = 1'b1;
      repeat (5) @(negedge clk_sys_i);
      sys_rst_i = 1'b0;
      repeat (10) @(negedge clk_sys_i);
      cap = strap;
   endtask : hw_reset

   // expected register view: only the writable fields plus the captured address
   task automatic read_view(input logic [15:0] fields);
      i_mgmt_model.rd(EXT_CTRL_ADDR, d, ok);
      chk_bit(ok, 1'b1);
      chk16(d, (fields & 16'h802d) | {5'h00, cap, 6'h00});
      chk16({11'h0, phy_addr_o}, {11'h0, cap});
   endtask : read_view

   // one nibble through the fifo, then its five line bits compared
   task automatic send(input logic [3:0] n, input logic er);
      logic [4:0] s;
      logic       lvl;
      int         i;
      s = exp_sym(n, er);
      for (i = 0; i < 100 && tx_ready_o !== 1'b1; i++)
         @(negedge clk_sys_i);
      if (i == 100)
      begin
         failures++;
         conclude();
      end
      tx_valid_i  = 1'b1;
      tx_nibble_i = n;
      tx_er_i     = er;
      @(negedge clk_sys_i);
      tx_valid_i  = 1'b0;
      tx_nibble_i = ~n;
      lvl = tx_bit_o;
      // fifo slot, output stage, then shifter load before the first bit
      repeat (2) @(negedge clk_sys_i);
      for (i = 4; i >= 0; i--)
      begin
         @(negedge clk_sys_i);
         lvl = (speed_100_i && nrzi) ? lvl ^ s[i] : s[i];
         chk_bit(tx_bit_o, lvl);
      end
   endtask : send

   // main sequence
   initial
   begin
      void'($urandom(79965));
      clk_sys_i = 1'b0;
      sys_rst_i = 1'b1;
      soft_rst_i = 1'b0;
      speed_100_i = 1'b1;
      tx_valid_i = 1'b0;
      tx_nibble_i = 4'h0;
      tx_er_i = 1'b0;
      strap = 5'($urandom);
      failures = 0;
      n_checks = 0;
      hw_reset();
      read_view(16'h0008);
      strap = ~strap;
      for (k = 0; k < 8; k++)
      begin
         w = 16'($urandom);
         i_mgmt_model.wr(EXT_CTRL_ADDR, w);
         read_view(w);
      end
      // override arms for exactly one following write
      i_mgmt_model.wr(EXT_CTRL_ADDR, 16'h8008);
      chk_bit(override_en_o, 1'b1);
      i_mgmt_model.wr(5'h00, 16'h1234);
      chk_bit(prot_wr_o, 1'b1);
      chk_bit(override_en_o, 1'b0);
      i_mgmt_model.wr(5'h00, 16'h1234);
      chk_bit(prot_wr_o, 1'b0);
      i_mgmt_model.wr_prot(EXT_CTRL_ADDR, 16'h0008);
      chk_bit(prot_wr_o, 1'b1);
      chk_bit(override_en_o, 1'b0);
      // soft reset restores fields and keeps the address
      i_mgmt_model.wr(EXT_CTRL_ADDR, 16'h0025);
      @(negedge clk_sys_i);
      soft_rst_i = 1'b1;
      @(negedge clk_sys_i);
      soft_rst_i = 1'b0;
      read_view(16'h0008);
      // scrambler controls only at 100 Mb/s
      for (m = 0; m < 2; m++)
      begin
         speed_100_i = m[0];
         i_mgmt_model.wr(EXT_CTRL_ADDR, 16'h0029);
         repeat (2) @(negedge clk_sys_i);
         chk_bit(scr_bypass_o, m[0]);
         chk_bit(descr_unlock_o, m[0]);
         i_mgmt_model.wr(EXT_CTRL_ADDR, 16'h0008);
         repeat (2) @(negedge clk_sys_i);
         chk_bit(scr_bypass_o, 1'b0);
         chk_bit(descr_unlock_o, 1'b0);
      end
      // coding modes: {speed, nrzi, inv}
      for (m = 0; m < 4; m++)
      begin
         {speed_100_i, nrzi, inv} = (m == 0) ? 3'h6 : (m == 1) ? 3'h5 : (m == 2) ? 3'h3 : 3'h7;
         i_mgmt_model.wr(EXT_CTRL_ADDR, {12'h000, nrzi, inv, 2'h0});
         for (k = 0; k < 16; k++)
            send(4'(k), inv);
         for (k = 0; k < 6; k++)
            send(4'($urandom), 1'($urandom));
      end
      // fill the fifo until it refuses, then let it drain
      @(negedge clk_sys_i);
      tx_valid_i = 1'b1;
      for (k = 0; k < 40 && tx_ready_o === 1'b1; k++)
      begin
         tx_nibble_i = 4'($urandom);
         @(negedge clk_sys_i);
      end
      tx_valid_i = 1'b0;
      // sixteen buffered, one in the output stage, one in the shifter, three drained
      chk16(16'(k), 16'(FIFO_DEPTH + 5));
      repeat (120) @(negedge clk_sys_i);
      chk_bit(tx_ready_o, 1'b1);
      // unmapped address gives no answer
      i_mgmt_model.rd(5'h11, d, ok);
      chk_bit(ok, 1'b0);
      // second hardware reset takes the new straps
      strap = 5'($urandom);
      hw_reset();
      read_view(16'h0008);
      conclude();
   end
endmodule : phy_extended_control_tb_top
